// File: opsw_pkg.sv
package opsw_pkg;

  localparam int unsigned OPSW_ADDR_W = 8;
  localparam int unsigned OPSW_DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OPSW_OFS_AMP1_STATUS  = 8'h00;
  localparam logic [7:0] OPSW_OFS_AMP1_CONTROL = 8'h01;
  localparam logic [7:0] OPSW_OFS_AMP2_STATUS  = 8'h02;
  localparam logic [7:0] OPSW_OFS_AMP2_CONTROL = 8'h03;
  localparam logic [7:0] OPSW_OFS_AMP2_PATH    = 8'h04;

  // Reset values
  localparam logic [7:0] OPSW_RST_STATUS  = 8'h00;
  localparam logic [7:0] OPSW_RST_CONTROL = 8'h0C;
  localparam logic [7:0] OPSW_RST_PATH    = 8'h00;
  localparam logic [7:0] OPSW_RST_RDATA   = 8'h00;

  // Status field
  localparam int unsigned OPSW_ST_OUT = 7;

  // Control fields, same layout for both amplifiers
  localparam int unsigned OPSW_CT_CMP   = 7;
  localparam int unsigned OPSW_CT_FB    = 6;
  localparam int unsigned OPSW_CT_REF_H = 5;
  localparam int unsigned OPSW_CT_REF_L = 4;
  localparam int unsigned OPSW_CT_POS   = 3;
  localparam int unsigned OPSW_CT_NEG   = 2;
  localparam int unsigned OPSW_CT_DRV   = 1;
  localparam int unsigned OPSW_CT_EN    = 0;

  // Path and gain fields
  localparam int unsigned OPSW_PG_CINV  = 7;
  localparam int unsigned OPSW_PG_CNINV = 6;
  localparam int unsigned OPSW_PG_RSV_H = 5;
  localparam int unsigned OPSW_PG_RSV_L = 4;
  localparam int unsigned OPSW_PG_GEN   = 3;
  localparam int unsigned OPSW_PG_GS_H  = 2;
  localparam int unsigned OPSW_PG_GS_L  = 0;

  // Reference select codes
  localparam logic [1:0] OPSW_REF_NONE = 2'h0;
  localparam logic [1:0] OPSW_REF_HIGH = 2'h1;
  localparam logic [1:0] OPSW_REF_MID  = 2'h2;
  localparam logic [1:0] OPSW_REF_LOW  = 2'h3;

  // Gain figures
  localparam logic [5:0] OPSW_GAIN_UNITY = 6'h01;
  localparam logic [2:0] OPSW_GAIN_STEP0 = 3'h0;

  typedef struct packed {
    logic       cmp_route;
    logic       pos_pin;
    logic       neg_pin;
    logic       feedback;
    logic [2:0] ref_sw;
    logic       power;
    logic       drive;
  } opsw_amp1_sw_s;

  typedef struct packed {
    logic       cmp_route;
    logic       pos_pin;
    logic       neg_pin;
    logic       buffer;
    logic       gain_a;
    logic       gain_b;
    logic       casc_inv;
    logic       casc_ninv;
    logic [2:0] ref_sw;
    logic       power;
    logic       drive;
  } opsw_amp2_sw_s;

  typedef struct packed {
    logic pos_in;
    logic neg_in;
    logic out;
  } opsw_pins_s;

  // Hardware clears on a control byte
  function automatic logic [7:0] opsw_fix_ctrl(input logic [7:0] c);
    logic [7:0] r;
    r = c;
    if (!c[OPSW_CT_EN]) begin
      r[OPSW_CT_FB] = 1'b0;
    end
    if (c[OPSW_CT_POS]) begin
      r[OPSW_CT_REF_H:OPSW_CT_REF_L] = OPSW_REF_NONE;
    end
    return r;
  endfunction

  // Hardware clears on the path and gain byte
  function automatic logic [7:0] opsw_fix_path(input logic [7:0] p, input logic [7:0] c2);
    logic [7:0] r;
    r = p;
    r[OPSW_PG_RSV_H:OPSW_PG_RSV_L] = 2'h0;
    if (!c2[OPSW_CT_EN]) begin
      r[OPSW_PG_GEN] = 1'b0;
    end
    if (c2[OPSW_CT_POS]) begin
      r[OPSW_PG_CNINV] = 1'b0;
    end
    if (c2[OPSW_CT_NEG]) begin
      r[OPSW_PG_CINV] = 1'b0;
    end
    return r;
  endfunction

endpackage

// File: opsw_ref_dec.sv
`timescale 1ns/1ns
module opsw_ref_dec
  import opsw_pkg::*;
(
  input  wire logic [1:0] i_sel,
  output logic      [2:0] o_ref_sw
);

  // One switch per nonzero code, bit 0 high, bit 1 mid, bit 2 low
  always_comb begin
    o_ref_sw = 3'h0;
    case (i_sel)
      OPSW_REF_HIGH: o_ref_sw = 3'h1;
      OPSW_REF_MID:  o_ref_sw = 3'h2;
      OPSW_REF_LOW:  o_ref_sw = 3'h4;
      default:       o_ref_sw = 3'h0;
    endcase
  end

endmodule // opsw_ref_dec

// File: opsw_gain_dec.sv
`timescale 1ns/1ns
module opsw_gain_dec
  import opsw_pkg::*;
(
  input  wire logic [2:0] i_gain_select,
  output logic      [5:0] o_gain
);

  // Code 0 is unity, every other code is eight per step
  always_comb begin
    if (i_gain_select == OPSW_GAIN_STEP0) begin
      o_gain = OPSW_GAIN_UNITY;
    end else begin
      o_gain = {i_gain_select, 3'h0};
    end
  end

endmodule // opsw_gain_dec

// File: opsw_regs.sv
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
module opsw_regs
  import opsw_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset_n,
  input  wire logic [OPSW_ADDR_W-1:0] i_addr,
  input  wire logic [OPSW_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic                   i_amp1_out_level,
  input  wire logic                   i_amp2_out_level,
  output logic      [OPSW_DATA_W-1:0] o_rdata,
  output opsw_amp1_sw_s               o_amp1_sw,
  output opsw_amp2_sw_s               o_amp2_sw,
  output opsw_pins_s                  o_amp1_pins,
  output opsw_pins_s                  o_amp2_pins,
  output logic      [5:0]             o_amp2_gain
);

  logic [7:0] amp1_stat_ff;
  logic [7:0] amp2_stat_ff;
  logic [7:0] amp1_ctrl_ff;
  logic [7:0] amp2_ctrl_ff;
  logic [7:0] path_ff;
  logic [7:0] nxt_amp1_ctrl;
  logic [7:0] nxt_amp2_ctrl;
  logic [7:0] nxt_path;
  logic [7:0] rdata_ff;
  logic [2:0] ref1_sw;
  logic [2:0] ref2_sw;
  logic [5:0] gain_val;
  logic       wr_amp1;
  logic       wr_amp2;
  logic       wr_path;
  opsw_amp1_sw_s amp1_sw_ff;
  opsw_amp2_sw_s amp2_sw_ff;
  opsw_pins_s    amp1_pins_ff;
  opsw_pins_s    amp2_pins_ff;
  logic [5:0]    gain_ff;

  assign wr_amp1 = i_wr && (i_addr == OPSW_OFS_AMP1_CONTROL);
  assign wr_amp2 = i_wr && (i_addr == OPSW_OFS_AMP2_CONTROL);
  assign wr_path = i_wr && (i_addr == OPSW_OFS_AMP2_PATH);

  // Next register values with the hardware clears applied
  always_comb begin
    nxt_amp1_ctrl = opsw_fix_ctrl(wr_amp1 ? i_wdata : amp1_ctrl_ff);
    nxt_amp2_ctrl = opsw_fix_ctrl(wr_amp2 ? i_wdata : amp2_ctrl_ff);
    nxt_path      = opsw_fix_path(wr_path ? i_wdata : path_ff, nxt_amp2_ctrl);
  end

  // Control registers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp1_ctrl_ff <= OPSW_RST_CONTROL;
      amp2_ctrl_ff <= OPSW_RST_CONTROL;
      path_ff      <= OPSW_RST_PATH;
    end else begin
      amp1_ctrl_ff <= nxt_amp1_ctrl;
      amp2_ctrl_ff <= nxt_amp2_ctrl;
      path_ff      <= nxt_path;
    end
  end

  // Output level mirrors, writes have no effect
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp1_stat_ff <= OPSW_RST_STATUS;
      amp2_stat_ff <= OPSW_RST_STATUS;
    end else begin
      amp1_stat_ff <= {i_amp1_out_level, 7'h00};
      amp2_stat_ff <= {i_amp2_out_level, 7'h00};
    end
  end

  // Read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= OPSW_RST_RDATA;
    end else if (i_rd) begin
      case (i_addr)
        OPSW_OFS_AMP1_STATUS:  rdata_ff <= amp1_stat_ff;
        OPSW_OFS_AMP1_CONTROL: rdata_ff <= amp1_ctrl_ff;
        OPSW_OFS_AMP2_STATUS:  rdata_ff <= amp2_stat_ff;
        OPSW_OFS_AMP2_CONTROL: rdata_ff <= amp2_ctrl_ff;
        OPSW_OFS_AMP2_PATH:    rdata_ff <= path_ff;
        default:               rdata_ff <= OPSW_RST_RDATA;
      endcase
    end else begin
      rdata_ff <= OPSW_RST_RDATA;
    end
  end

  opsw_ref_dec u_ref1 (
    .i_sel    (nxt_amp1_ctrl[OPSW_CT_REF_H:OPSW_CT_REF_L]),
    .o_ref_sw (ref1_sw)
  );

  opsw_ref_dec u_ref2 (
    .i_sel    (nxt_amp2_ctrl[OPSW_CT_REF_H:OPSW_CT_REF_L]),
    .o_ref_sw (ref2_sw)
  );

  opsw_gain_dec u_gain (
    .i_gain_select (nxt_path[OPSW_PG_GS_H:OPSW_PG_GS_L]),
    .o_gain        (gain_val)
  );

  // Amplifier 1 switches and pins
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp1_sw_ff   <= '0;
      amp1_pins_ff <= '0;
    end else begin
      amp1_sw_ff.cmp_route <= nxt_amp1_ctrl[OPSW_CT_CMP];
      amp1_sw_ff.pos_pin   <= nxt_amp1_ctrl[OPSW_CT_POS];
      amp1_sw_ff.neg_pin   <= nxt_amp1_ctrl[OPSW_CT_NEG];
      amp1_sw_ff.feedback  <= nxt_amp1_ctrl[OPSW_CT_FB];
      amp1_sw_ff.ref_sw    <= ref1_sw;
      amp1_sw_ff.power     <= nxt_amp1_ctrl[OPSW_CT_EN];
      amp1_sw_ff.drive     <= nxt_amp1_ctrl[OPSW_CT_DRV] && nxt_amp1_ctrl[OPSW_CT_EN];
      amp1_pins_ff.out     <= nxt_amp1_ctrl[OPSW_CT_EN];
      amp1_pins_ff.pos_in  <= nxt_amp1_ctrl[OPSW_CT_EN] && nxt_amp1_ctrl[OPSW_CT_POS];
      amp1_pins_ff.neg_in  <= nxt_amp1_ctrl[OPSW_CT_EN] && nxt_amp1_ctrl[OPSW_CT_NEG];
    end
  end

  // Amplifier 2 switches and pins
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      amp2_sw_ff   <= '0;
      amp2_pins_ff <= '0;
    end else begin
      amp2_sw_ff.cmp_route <= nxt_amp2_ctrl[OPSW_CT_CMP];
      amp2_sw_ff.pos_pin   <= nxt_amp2_ctrl[OPSW_CT_POS];
      amp2_sw_ff.neg_pin   <= nxt_amp2_ctrl[OPSW_CT_NEG];
      amp2_sw_ff.buffer    <= nxt_amp2_ctrl[OPSW_CT_FB];
      amp2_sw_ff.gain_a    <= nxt_path[OPSW_PG_GEN];
      amp2_sw_ff.gain_b    <= nxt_path[OPSW_PG_GEN];
      amp2_sw_ff.casc_inv  <= nxt_path[OPSW_PG_CINV];
      amp2_sw_ff.casc_ninv <= nxt_path[OPSW_PG_CNINV];
      amp2_sw_ff.ref_sw    <= ref2_sw;
      amp2_sw_ff.power     <= nxt_amp2_ctrl[OPSW_CT_EN];
      amp2_sw_ff.drive     <= nxt_amp2_ctrl[OPSW_CT_DRV] && nxt_amp2_ctrl[OPSW_CT_EN];
      amp2_pins_ff.out     <= nxt_amp2_ctrl[OPSW_CT_EN];
      amp2_pins_ff.pos_in  <= nxt_amp2_ctrl[OPSW_CT_EN] && nxt_amp2_ctrl[OPSW_CT_POS];
      amp2_pins_ff.neg_in  <= nxt_amp2_ctrl[OPSW_CT_EN]
                              && (nxt_amp2_ctrl[OPSW_CT_NEG] || nxt_path[OPSW_PG_GEN]);
    end
  end

  // Gain figure
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gain_ff <= OPSW_GAIN_UNITY;
    end else begin
      gain_ff <= gain_val;
    end
  end

  assign o_rdata     = rdata_ff;
  assign o_amp1_sw   = amp1_sw_ff;
  assign o_amp2_sw   = amp2_sw_ff;
  assign o_amp1_pins = amp1_pins_ff;
  assign o_amp2_pins = amp2_pins_ff;
  assign o_amp2_gain = gain_ff;

  default clocking cb @(posedge i_core_clk);
  endclocking

  default disable iff (!i_reset_n);

  sequence s_read_path;
    i_rd && (i_addr == OPSW_OFS_AMP2_PATH);
  endsequence

  sequence s_read_status;
    i_rd && ((i_addr == OPSW_OFS_AMP1_STATUS) || (i_addr == OPSW_OFS_AMP2_STATUS));
  endsequence

  sequence s_write_status1;
    i_wr && (i_addr == OPSW_OFS_AMP1_STATUS);
  endsequence

  a_status_mirror: assert property (
    s_write_status1 |=> amp1_stat_ff[OPSW_ST_OUT] == $past(i_amp1_out_level)
      && amp1_stat_ff[6:0] == 7'h00)
    else $error("amp1 status bit does not follow output level");

  a_status_read: assert property (
    i_rd && (i_addr == OPSW_OFS_AMP2_STATUS) |=>
      o_rdata == {$past(i_amp2_out_level, 2), 7'h00})
    else $error("amp2 status read does not show output level");

  a_status_zero: assert property (
    s_read_status |=> o_rdata[6:0] == 7'h00)
    else $error("status undefined bits not zero");

  a_cmp_route: assert property (
    o_amp1_sw.cmp_route == amp1_ctrl_ff[OPSW_CT_CMP])
    else $error("amp1 comparator route switch mismatch");

  a_fb1_forced: assert property (
    !amp1_ctrl_ff[OPSW_CT_EN] |-> !amp1_ctrl_ff[OPSW_CT_FB] && !o_amp1_sw.feedback)
    else $error("amp1 feedback active while disabled");

  a_ref1_decode: assert property (
    $onehot0(o_amp1_sw.ref_sw)
      && (o_amp1_sw.ref_sw[0] == (amp1_ctrl_ff[OPSW_CT_REF_H:OPSW_CT_REF_L] == OPSW_REF_HIGH))
      && (o_amp1_sw.ref_sw[1] == (amp1_ctrl_ff[OPSW_CT_REF_H:OPSW_CT_REF_L] == OPSW_REF_MID))
      && (o_amp1_sw.ref_sw[2] == (amp1_ctrl_ff[OPSW_CT_REF_H:OPSW_CT_REF_L] == OPSW_REF_LOW)))
    else $error("amp1 reference switch decode wrong");

  a_ref1_clear: assert property (
    amp1_ctrl_ff[OPSW_CT_POS] |-> o_amp1_sw.ref_sw == 3'h0
      && amp1_ctrl_ff[OPSW_CT_REF_H:OPSW_CT_REF_L] == OPSW_REF_NONE)
    else $error("amp1 reference not cleared by positive pin");

  a_amp1_buffer: assert property (
    wr_amp1 && i_wdata[OPSW_CT_EN] && i_wdata[OPSW_CT_POS] && i_wdata[OPSW_CT_FB]
      && !i_wdata[OPSW_CT_NEG] |=> o_amp1_sw.pos_pin && o_amp1_sw.feedback
      && !o_amp1_sw.neg_pin)
    else $error("amp1 unity buffer switches wrong");

  a_amp1_connect: assert property (
    wr_amp1 |=> o_amp1_sw.pos_pin == amp1_ctrl_ff[OPSW_CT_POS]
      && o_amp1_sw.neg_pin == amp1_ctrl_ff[OPSW_CT_NEG])
    else $error("amp1 connect switches do not follow their bits");

  a_drive_off: assert property (
    !amp1_ctrl_ff[OPSW_CT_EN] |-> !o_amp1_sw.drive && !o_amp1_sw.power)
    else $error("amp1 output drive on while disabled");

  a_pins1_io: assert property (
    !amp1_ctrl_ff[OPSW_CT_EN] |-> o_amp1_pins == 3'h0)
    else $error("amp1 pins not I/O while disabled");

  a_pins1_on: assert property (
    amp1_ctrl_ff[OPSW_CT_EN] |-> o_amp1_pins.out
      && (o_amp1_pins.pos_in == amp1_ctrl_ff[OPSW_CT_POS])
      && (o_amp1_pins.neg_in == amp1_ctrl_ff[OPSW_CT_NEG]))
    else $error("amp1 pin sharing wrong while enabled");

  a_amp2_off: assert property (
    !amp2_ctrl_ff[OPSW_CT_EN] |-> !path_ff[OPSW_PG_GEN] && !amp2_ctrl_ff[OPSW_CT_FB])
    else $error("amp2 disabled but gain or feedback set");

  a_casc_pos: assert property (
    amp2_ctrl_ff[OPSW_CT_POS] |-> !path_ff[OPSW_PG_CNINV] && o_amp2_sw.ref_sw == 3'h0)
    else $error("amp2 positive pin did not clear cascade or reference");

  a_casc_neg: assert property (
    wr_path && i_wdata[OPSW_PG_CINV] && amp2_ctrl_ff[OPSW_CT_NEG] && !wr_amp2
      |=> !o_amp2_sw.casc_inv)
    else $error("amp2 negative pin did not clear inverting cascade");

  a_ref2_decode: assert property (
    wr_amp2 && !i_wdata[OPSW_CT_POS]
      && i_wdata[OPSW_CT_REF_H:OPSW_CT_REF_L] == OPSW_REF_MID |=> o_amp2_sw.ref_sw == 3'h2)
    else $error("amp2 reference decode wrong");

  a_gain_value: assert property (
    wr_path |=> o_amp2_gain == (($past(i_wdata[2:0]) == 3'h0) ? 6'h01
      : {$past(i_wdata[2:0]), 3'h0}))
    else $error("gain figure wrong");

  a_gain_switch: assert property (
    o_amp2_sw.gain_a == path_ff[OPSW_PG_GEN] && o_amp2_sw.gain_b == o_amp2_sw.gain_a)
    else $error("gain switches do not follow gain enable");

  a_amp2_open: assert property (
    !o_amp2_sw.power |-> !o_amp2_sw.gain_a && !o_amp2_sw.gain_b && !o_amp2_sw.buffer)
    else $error("amp2 switches closed while disabled");

  a_path_rsvd: assert property (
    s_read_path |=> o_rdata[5:4] == 2'h0)
    else $error("path reserved bits not zero");

endmodule // opsw_regs

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import opsw_pkg::*;
  logic                   i_core_clk;
  logic                   i_reset_n;
  logic [OPSW_ADDR_W-1:0] i_addr;
  logic [OPSW_DATA_W-1:0] i_wdata;
  logic                   i_wr;
  logic                   i_rd;
  logic                   i_amp1_out_level;
  logic                   i_amp2_out_level;
  logic [OPSW_DATA_W-1:0] o_rdata;
  opsw_amp1_sw_s          o_amp1_sw;
  opsw_amp2_sw_s          o_amp2_sw;
  opsw_pins_s             o_amp1_pins;
  opsw_pins_s             o_amp2_pins;
  logic [5:0]             o_amp2_gain;
  logic [7:0]             exp_q[$];
  logic [7:0]             m_c1;
  logic [7:0]             m_c2;
  logic [7:0]             m_pg;
  logic [31:0]            lfsr;
  logic [31:0]            r;
  logic                   rd_pend = 1'b0;
  int                     n_fail = 0;
  int                     n_tests = 0;

  opsw_regs opsw_regs_inst (
    .i_core_clk       (i_core_clk),
    .i_reset_n        (i_reset_n),
    .i_addr           (i_addr),
    .i_wdata          (i_wdata),
    .i_wr             (i_wr),
    .i_rd             (i_rd),
    .i_amp1_out_level (i_amp1_out_level),
    .i_amp2_out_level (i_amp2_out_level),
    .o_rdata          (o_rdata),
    .o_amp1_sw        (o_amp1_sw),
    .o_amp2_sw        (o_amp2_sw),
    .o_amp1_pins      (o_amp1_pins),
    .o_amp2_pins      (o_amp2_pins),
    .o_amp2_gain      (o_amp2_gain)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [2:0] dec(input logic [1:0] s);
    return (s == 2'h0) ? 3'h0 : (3'h1 << (s - 2'h1));
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Model of the hardware clears, applied after every write
  task automatic settle();
    if (!m_c1[0]) m_c1[6] = 1'b0;
    if (m_c1[3]) m_c1[5:4] = 2'h0;
    if (!m_c2[0]) m_c2[6] = 1'b0;
    if (m_c2[3]) m_c2[5:4] = 2'h0;
    m_pg[5:4] = 2'h0;
    if (!m_c2[0]) m_pg[3] = 1'b0;
    if (m_c2[3]) m_pg[6] = 1'b0;
    if (m_c2[2]) m_pg[7] = 1'b0;
  endtask

  function automatic logic [7:0] rdv(input logic [7:0] a);
    case (a)
      8'h00:   return {i_amp1_out_level, 7'h00};
      8'h01:   return m_c1;
      8'h02:   return {i_amp2_out_level, 7'h00};
      8'h03:   return m_c2;
      8'h04:   return m_pg;
      default: return 8'h00;
    endcase
  endfunction

  // One bus cycle; the strobe stays up for a following op with no gap
  task automatic op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr    <= wr;
    i_rd    <= !wr;
    i_addr  <= a;
    i_wdata <= d;
    if (wr) begin
      case (a)
        8'h01:   m_c1 = d;
        8'h03:   m_c2 = d;
        8'h04:   m_pg = d;
        default: ;
      endcase
      settle();
    end else begin
      exp_q.push_back(rdv(a));
    end
  endtask

  task automatic idle();
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  task automatic chk_out();
    logic [12:0] e2;
    logic [5:0]  pins;
    e2 = {m_c2[7], m_c2[3], m_c2[2], m_c2[6], m_pg[3], m_pg[3], m_pg[7], m_pg[6],
          dec(m_c2[5:4]), m_c2[0], m_c2[1] & m_c2[0]};
    pins = {m_c1[0] & m_c1[3], m_c1[0] & m_c1[2], m_c1[0],
            m_c2[0] & m_c2[3], m_c2[0] & (m_c2[2] | m_pg[3]), m_c2[0]};
    @(negedge i_core_clk);
    check({7'h00, o_amp1_sw}, {7'h00, m_c1[7], m_c1[3], m_c1[2], m_c1[6], dec(m_c1[5:4]),
          m_c1[0], m_c1[1] & m_c1[0]}, "amp1 switches");
    check({3'h0, o_amp2_sw}, {3'h0, e2}, "amp2 switches");
    check({10'h000, o_amp1_pins, o_amp2_pins}, {10'h000, pins}, "pins");
    check({10'h000, o_amp2_gain}, {10'h000, (m_pg[2:0] == 3'h0) ? 6'h01 : {m_pg[2:0], 3'h0}},
          "gain");
  endtask

  // Result watcher: read data stand only in the cycle after the read strobe
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rd_pend <= 1'b0;
    end else begin
      if (rd_pend) begin
        if (exp_q.size() == 0) begin
          n_fail++;
          $display("wrong value at %0t: read data with no request", $time);
        end else begin
          check({8'h00, o_rdata}, {8'h00, exp_q.pop_front()}, "read data");
        end
      end else begin
        check({8'h00, o_rdata}, 16'h0000, "idle read data");
      end
      rd_pend <= i_rd;
    end
  end

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    $display("wrong value at %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_amp1_out_level = 1'b0;
    i_amp2_out_level = 1'b0;
    lfsr = 32'h0446F615;
    m_c1 = OPSW_RST_CONTROL;
    m_c2 = OPSW_RST_CONTROL;
    m_pg = OPSW_RST_PATH;
    repeat (5) @(posedge i_core_clk);
    check({10'h000, o_amp2_gain}, 16'h0001, "gain in reset");
    check({3'h0, o_amp2_sw}, 16'h0000, "amp2 switches in reset");
    check({8'h00, o_rdata}, 16'h0000, "read data in reset");
    i_reset_n <= 1'b1;
    for (int a = 0; a < 6; a++) op(1'b0, 8'(a), 8'h00);
    op(1'b0, 8'hFF, 8'h00);
    idle();
    chk_out();
    $display("test reset values done at %0t", $time);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_core_clk);
      i_amp1_out_level <= k[0];
      i_amp2_out_level <= k[1];
      op(1'b1, 8'h00, 8'hFF);
      op(1'b1, 8'h02, 8'h7F);
      op(1'b0, 8'h00, 8'h00);
      op(1'b0, 8'h02, 8'h00);
      idle();
    end
    $display("test status bits done at %0t", $time);
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 8'h01, {2'h0, k[1:0], k[2], 3'h5});
      op(1'b1, 8'h03, {2'h0, k[1:0], k[2], 3'h5});
      op(1'b0, 8'h01, 8'h00);
      op(1'b0, 8'h03, 8'h00);
      idle();
      chk_out();
    end
    $display("test reference codes done at %0t", $time);
    op(1'b1, 8'h03, 8'h01);
    for (int g = 0; g < 8; g++) begin
      op(1'b1, 8'h04, {4'h3, g[0], g[2:0]});
      op(1'b0, 8'h04, 8'h00);
      idle();
      chk_out();
    end
    $display("test gain codes done at %0t", $time);
    op(1'b1, 8'h01, 8'hC3);
    op(1'b1, 8'h03, 8'hC3);
    op(1'b1, 8'h04, 8'hFD);
    op(1'b0, 8'h04, 8'h00);
    idle();
    chk_out();
    op(1'b1, 8'h03, 8'h0C);
    op(1'b0, 8'h04, 8'h00);
    op(1'b1, 8'h01, 8'h40);
    op(1'b0, 8'h01, 8'h00);
    idle();
    chk_out();
    $display("test hardware clears done at %0t", $time);
    op(1'b1, 8'h01, 8'h05);
    op(1'b1, 8'h01, 8'h25);
    op(1'b1, 8'h01, 8'hA5);
    op(1'b1, 8'h01, 8'h25);
    op(1'b1, 8'h03, 8'h01);
    op(1'b1, 8'h04, 8'hC8);
    op(1'b0, 8'h04, 8'h00);
    op(1'b1, 8'h04, 8'h88);
    op(1'b1, 8'h03, 8'hB1);
    op(1'b0, 8'h01, 8'h00);
    op(1'b0, 8'h03, 8'h00);
    op(1'b0, 8'h04, 8'h00);
    idle();
    chk_out();
    $display("test software ordering done at %0t", $time);
    for (int n = 0; n < 80; n++) begin
      r = rnd();
      @(posedge i_core_clk);
      i_amp1_out_level <= r[8];
      i_amp2_out_level <= r[9];
      op(1'b1, {5'h00, r[2:0]}, r[23:16]);
      op(1'b0, {5'h00, r[2:0]}, 8'h00);
      op(1'b0, {5'h00, r[5:3]}, 8'h00);
      idle();
      chk_out();
    end
    $display("test random traffic done at %0t", $time);
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    check({8'h00, o_rdata}, 16'h0000, "read data in second reset");
    check({7'h00, o_amp1_sw}, 16'h0000, "amp1 switches in second reset");
    check({10'h000, o_amp1_pins, o_amp2_pins}, 16'h0000, "pins in second reset");
    i_reset_n <= 1'b1;
    m_c1 = OPSW_RST_CONTROL;
    m_c2 = OPSW_RST_CONTROL;
    m_pg = OPSW_RST_PATH;
    for (int a = 0; a < 5; a++) op(1'b0, 8'(a), 8'h00);
    idle();
    chk_out();
    $display("test second reset done at %0t", $time);
    repeat (3) @(posedge i_core_clk);
    complete_run();
  end
endmodule // tb
